// ==== fwg_pkg.sv ====
// constants, types and helpers shared by the flash rewrite guard
// assumes a 20-bit code flash byte address and 1 KB erase blocks
package fwg_pkg;
	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int FWG_AW = 20;
	localparam int FWG_BW = 10;
	localparam int FWG_BLK_LSB = 10;
	// each boot cluster spans 4 KB
	localparam int FWG_BC_BYTES = 4096;
	localparam int FWG_BC_LSB = $clog2(FWG_BC_BYTES);

	// ---------------------------------------------------------------
	// register offsets (byte addresses)
	// ---------------------------------------------------------------
	localparam logic [7:0] FWG_OFS_VOLT = 8'h00;
	localparam logic [7:0] FWG_OFS_SEC = 8'h04;
	localparam logic [7:0] FWG_OFS_WIN = 8'h08;
	localparam logic [7:0] FWG_OFS_SWAP = 8'h0C;
	localparam logic [7:0] FWG_OFS_REL = 8'h10;
	localparam logic [7:0] FWG_OFS_STAT = 8'h14;

	// ---------------------------------------------------------------
	// field positions and reset values
	// ---------------------------------------------------------------
	localparam int FWG_SEC_BEP = 0;
	localparam int FWG_SEC_WP = 1;
	localparam int FWG_SEC_BC0 = 2;
	localparam int FWG_WIN_HI_LSB = 16;
	localparam int FWG_STAT_CODE_LSB = 1;
	localparam int FWG_STAT_FULL = 4;
	localparam int FWG_STAT_LOCK = 5;
	localparam int FWG_STAT_BOOT = 6;
	localparam logic [7:0] FWG_VOLT_FULL = 8'h00;
	localparam logic [7:0] FWG_VOLT_RST = 8'h00;
	localparam logic [9:0] FWG_WIN_LO_RST = 10'h000;
	localparam logic [9:0] FWG_WIN_HI_RST = 10'h3FF;

	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		FWG_OK = 3'b000,
		FWG_SUBCLK = 3'b001,
		FWG_BC0 = 3'b010,
		FWG_WINDOW = 3'b011,
		FWG_ERASE = 3'b100,
		FWG_WRITE = 3'b101
	} fwg_code_t;

	typedef struct packed {
		logic serial;
		logic op_write;
		logic data_fl;
		logic [FWG_AW-1:0] addr;
	} fwg_req_t;

	typedef struct packed {
		logic err;
		fwg_code_t code;
	} fwg_rsp_t;

	typedef struct packed {
		logic bep;
		logic wp;
		logic bc0p;
		logic swap;
		logic [FWG_BW-1:0] win_lo;
		logic [FWG_BW-1:0] win_hi;
	} fwg_sec_t;

	// block number of a code flash address
	function automatic logic [FWG_BW-1:0] fwg_blk(
		input logic [FWG_AW-1:0] a);
		fwg_blk = a[FWG_BLK_LSB +: FWG_BW];
	endfunction : fwg_blk

	// address lies in the lowest boot cluster
	function automatic logic fwg_in_bc0(input logic [FWG_AW-1:0] a);
		fwg_in_bc0 = (a[FWG_AW-1:FWG_BC_LSB] == '0);
	endfunction : fwg_in_bc0
endpackage : fwg_pkg

// ==== fwg_nvstore.sv ====
// retained security settings: protections, shield window, boot swap
// assumes PORST_N models the shipped blank state; ARST_N leaves it
module fwg_nvstore
	import fwg_pkg::*;
(
	input wire logic clk,
	input wire logic porst_n,
	input wire logic [2:0] set_bits,
	input wire logic clr_wp,
	input wire logic swap_tgl,
	input wire logic win_we,
	input wire logic [FWG_BW-1:0] win_lo_d,
	input wire logic [FWG_BW-1:0] win_hi_d,
	output fwg_sec_t sec
);
	fwg_sec_t sec_r;
	fwg_sec_t sec_nxt;

	// set bits are sticky; a set beats a release in the same cycle
	always_comb begin
		sec_nxt = sec_r;
		sec_nxt.bep = sec_r.bep | set_bits[FWG_SEC_BEP];
		sec_nxt.wp = set_bits[FWG_SEC_WP] | (sec_r.wp & ~clr_wp);
		sec_nxt.bc0p = sec_r.bc0p | set_bits[FWG_SEC_BC0];
		sec_nxt.swap = sec_r.swap ^ swap_tgl;
		if (win_we) begin
			sec_nxt.win_lo = win_lo_d;
			sec_nxt.win_hi = win_hi_d;
		end
	end

	// shipped state: nothing protected, window covers all blocks
	always_ff @(posedge clk or negedge porst_n) begin
		if (!porst_n) begin
			sec_r <= '{bep: 1'b0, wp: 1'b0, bc0p: 1'b0, swap: 1'b0,
				win_lo: FWG_WIN_LO_RST, win_hi: FWG_WIN_HI_RST};
		end else begin
			sec_r <= sec_nxt;
		end
	end

	assign sec = sec_r;
endmodule : fwg_nvstore

// ==== fwg_check.sv ====
// decision logic: grants or refuses one erase or write request
// assumes request and settings stable while being judged
module fwg_check
	import fwg_pkg::*;
(
	input fwg_req_t req,
	input fwg_sec_t sec,
	input wire logic subclk,
	output fwg_code_t code
);
	wire code_fl;
	wire self_fl;
	wire ser_fl;
	wire hit_bc0;
	wire out_win;
	wire [FWG_BW-1:0] blk;

	// qualifiers
	assign code_fl = ~req.data_fl; // data flash bypasses every check
	assign self_fl = code_fl & ~req.serial;
	assign ser_fl = code_fl & req.serial;
	assign blk = fwg_blk(req.addr);
	assign hit_bc0 = code_fl & sec.bc0p & fwg_in_bc0(req.addr);
	// both window ends count as inside
	assign out_win = (blk < sec.win_lo) | (blk > sec.win_hi);

	// boot cluster guard is checked before the window
	assign code = (self_fl & subclk) ? FWG_SUBCLK :
		hit_bc0 ? FWG_BC0 :
		(self_fl & out_win) ? FWG_WINDOW :
		(ser_fl & ~req.op_write & sec.bep) ? FWG_ERASE :
		(ser_fl & req.op_write & sec.wp) ? FWG_WRITE :
		FWG_OK;
endmodule : fwg_check

// ==== fwg_top.sv ====
// flash rewrite guard: APB registers, request gate, boot selection
// assumes requesters hold REQ while REQ_VALID is high and unanswered
//
// Summary of operation
// - refuse self-programming on subsystem clock
// - argument zero selects full speed mode
// - swap exchanges two 4 KB boot clusters
// - recorded swap survives reset and selects boot
// - self-programming refused outside shield window
// - serial programming ignores the window
// - window settable from either requester
// - boot cluster guard beats the window
// - window never touches data flash
// - block erase ban hits serial only
// - write ban hits serial only
// - write ban release needs reset first
// - cluster guard refuses lowest 4 KB
// - shipped state has no protection
// - settings from both, any combination
module fwg_top
	import fwg_pkg::*;
(
	input wire logic CLK,
	input wire logic ARST_N,
	input wire logic PORST_N,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic REQ_VALID,
	input fwg_pkg::fwg_req_t REQ,
	output logic REQ_READY,
	output logic RSP_VALID,
	output fwg_pkg::fwg_rsp_t RSP,
	output logic FL_GO,
	output fwg_pkg::fwg_req_t FL_CMD,
	input wire logic CPU_SUBCLK,
	input wire logic SERIAL_MODE,
	input wire logic FLASH_BLANK,
	output logic FULL_SPEED,
	output logic BOOT_SWAPPED
);
	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	fwg_sec_t sec;
	fwg_code_t code;
	logic [7:0] volt_r;
	logic lock_r;
	logic boot_sel_r;
	logic boot_cap_r;
	logic rsp_valid_r;
	fwg_rsp_t rsp_r;
	logic fl_go_r;
	fwg_req_t fl_cmd_r;
	fwg_rsp_t last_r;
	logic [31:0] prdata_r;
	logic [31:0] rd_mux;
	wire setup;
	wire wr_acc;
	wire hit_volt;
	wire hit_sec;
	wire hit_win;
	wire hit_swap;
	wire hit_rel;
	wire hit_stat;
	wire mapped;
	wire [2:0] set_bits;
	wire rel_ok;
	wire clr_wp;
	wire swap_tgl;
	wire win_we;
	wire taken;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	assign setup = PSEL & ~PENABLE;
	assign wr_acc = PSEL & PENABLE & PWRITE;
	assign hit_volt = (PADDR == FWG_OFS_VOLT);
	assign hit_sec = (PADDR == FWG_OFS_SEC);
	assign hit_win = (PADDR == FWG_OFS_WIN);
	assign hit_swap = (PADDR == FWG_OFS_SWAP);
	assign hit_rel = (PADDR == FWG_OFS_REL);
	assign hit_stat = (PADDR == FWG_OFS_STAT);
	assign mapped = hit_volt | hit_sec | hit_win | hit_swap | hit_rel |
		hit_stat;

	// zero wait states; unmapped addresses answer with an error
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL & PENABLE & ~mapped;
	assign PRDATA = prdata_r;

	// settings writes, accepted whatever the requester
	assign set_bits = (wr_acc & hit_sec) ? PWDATA[2:0] : 3'b000;
	assign win_we = wr_acc & hit_win;
	assign swap_tgl = wr_acc & hit_swap & PWDATA[0];
	// release only from serial, after reset, with blank unguarded flash
	assign rel_ok = SERIAL_MODE & ~lock_r & ~sec.bep & ~sec.bc0p &
		FLASH_BLANK;
	assign clr_wp = wr_acc & hit_rel & PWDATA[0] & rel_ok;

	// read data selection
	always_comb begin
		rd_mux = 32'h0000_0000;
		if (hit_volt) begin
			rd_mux[7:0] = volt_r;
		end
		if (hit_sec) begin
			rd_mux[FWG_SEC_BEP] = sec.bep;
			rd_mux[FWG_SEC_WP] = sec.wp;
			rd_mux[FWG_SEC_BC0] = sec.bc0p;
		end
		if (hit_win) begin
			rd_mux[FWG_BW-1:0] = sec.win_lo;
			rd_mux[FWG_WIN_HI_LSB +: FWG_BW] = sec.win_hi;
		end
		if (hit_swap) begin
			rd_mux[0] = sec.swap;
			rd_mux[1] = boot_sel_r;
		end
		if (hit_stat) begin
			rd_mux[0] = last_r.err;
			rd_mux[FWG_STAT_CODE_LSB +: 3] = last_r.code;
			rd_mux[FWG_STAT_FULL] = FULL_SPEED;
			rd_mux[FWG_STAT_LOCK] = lock_r;
			rd_mux[FWG_STAT_BOOT] = boot_sel_r;
		end
	end

	// read data captured in the setup cycle
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			prdata_r <= 32'h0000_0000;
		end else if (setup & ~PWRITE) begin
			prdata_r <= rd_mux;
		end
	end

	// ---------------------------------------------------------------
	// mode argument and release lock
	// ---------------------------------------------------------------
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			volt_r <= FWG_VOLT_RST;
		end else if (wr_acc & hit_volt) begin
			volt_r <= PWDATA[7:0];
		end
	end

	assign FULL_SPEED = (volt_r == FWG_VOLT_FULL);

	// setting the write ban locks its release until the next reset
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			lock_r <= 1'b0;
		end else if (set_bits[FWG_SEC_WP]) begin
			lock_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// retained settings and boot selection
	// ---------------------------------------------------------------
	fwg_nvstore u_nv (
		.clk(CLK),
		.porst_n(PORST_N),
		.set_bits(set_bits),
		.clr_wp(clr_wp),
		.swap_tgl(swap_tgl),
		.win_we(win_we),
		.win_lo_d(PWDATA[FWG_BW-1:0]),
		.win_hi_d(PWDATA[FWG_WIN_HI_LSB +: FWG_BW]),
		.sec(sec)
	);

	// boot cluster picked once, at the first edge after reset release
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			boot_cap_r <= 1'b0;
			boot_sel_r <= 1'b0;
		end else if (!boot_cap_r) begin
			boot_cap_r <= 1'b1;
			boot_sel_r <= sec.swap;
		end
	end

	assign BOOT_SWAPPED = boot_sel_r;

	// ---------------------------------------------------------------
	// request gate
	// ---------------------------------------------------------------
	fwg_check u_chk (
		.req(REQ),
		.sec(sec),
		.subclk(CPU_SUBCLK),
		.code(code)
	);

	// one request in flight; the answer cycle blocks the next one
	assign REQ_READY = ~rsp_valid_r;
	assign taken = REQ_VALID & REQ_READY;

	// answer and flash command, one cycle after acceptance
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			rsp_valid_r <= 1'b0;
			rsp_r <= '{err: 1'b0, code: FWG_OK};
			fl_go_r <= 1'b0;
			fl_cmd_r <= '0;
			last_r <= '{err: 1'b0, code: FWG_OK};
		end else begin
			rsp_valid_r <= taken;
			fl_go_r <= taken & (code == FWG_OK);
			if (taken) begin
				rsp_r <= '{err: (code != FWG_OK), code: code};
				fl_cmd_r <= REQ;
				last_r <= '{err: (code != FWG_OK), code: code};
			end
		end
	end

	assign RSP_VALID = rsp_valid_r;
	assign RSP = rsp_r;
	assign FL_GO = fl_go_r;
	assign FL_CMD = fl_cmd_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	subclk_deny_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		taken && !REQ.serial && !REQ.data_fl && CPU_SUBCLK |=>
		RSP_VALID && RSP.err && !FL_GO)
		else $error("self request on subsystem clock not refused");

	volt_mode_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		wr_acc && hit_volt |=> FULL_SPEED == ($past(PWDATA[7:0]) == 8'h00))
		else $error("mode argument not applied");

	bc0_guard_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		taken && sec.bc0p && !REQ.data_fl && REQ.addr < FWG_BC_BYTES &&
		!(CPU_SUBCLK && !REQ.serial) |=> RSP.err && RSP.code == FWG_BC0)
		else $error("boot cluster 0 not guarded");

	win_out_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		taken && !REQ.serial && !REQ.data_fl &&
		fwg_blk(REQ.addr) > sec.win_hi |=> RSP.err && !FL_GO)
		else $error("self request outside window granted");

	win_edge_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		taken && !REQ.serial && !CPU_SUBCLK && !sec.bc0p &&
		(fwg_blk(REQ.addr) == sec.win_lo || fwg_blk(REQ.addr) == sec.win_hi)
		|=> !RSP.err ##0 FL_GO)
		else $error("window edge block refused");

	serial_win_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		taken && REQ.serial && !sec.bep && !sec.wp && !sec.bc0p |=>
		FL_GO && !RSP.err)
		else $error("serial request limited by window");

	data_free_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		taken && REQ.data_fl |=> FL_GO && FL_CMD.data_fl)
		else $error("data flash request refused");

	erase_ban_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		taken && REQ.serial && !REQ.op_write && !REQ.data_fl && sec.bep
		|=> RSP.err && !FL_GO)
		else $error("serial erase granted under erase ban");

	write_ban_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		taken && REQ.serial && REQ.op_write && !REQ.data_fl && sec.wp
		|=> RSP.err && !FL_GO)
		else $error("serial write granted under write ban");

	rel_lock_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		lock_r && sec.wp |=> sec.wp)
		else $error("write ban released before a reset");

	deny_quiet_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		RSP_VALID && RSP.err |-> !FL_GO ##1 !FL_GO)
		else $error("refused request reached the flash");

	boot_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
		boot_cap_r && $past(boot_cap_r) |-> $stable(BOOT_SWAPPED))
		else $error("boot selection changed without reset");
endmodule : fwg_top

// ==== fwg_flash_model.sv ====
// code flash array stand-in: counts the commands that reach it
// assumes commands arrive as one-cycle pulses on the system clock
module fwg_flash_model
	import fwg_pkg::*;
(
	input wire logic clk,
	input wire logic arst_n,
	input wire logic fl_go,
	input fwg_pkg::fwg_req_t fl_cmd,
	output logic [15:0] go_count_r
);
	timeunit 1ns;
	timeprecision 100ps;

	// only granted commands reach the array and raise its command count
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			go_count_r <= 16'h0000;
		end else if (fl_go) begin
			go_count_r <= go_count_r + 16'h0001;
		end
	end
endmodule : fwg_flash_model

// ==== fwg_tb_top.sv ====
// self-checking bench for the flash rewrite guard
// assumes the guard and the flash array model are compiled before it
`define CHK(g, x) chk(32'(g), 32'(x))
module fwg_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	import fwg_pkg::*;
	logic clk, arst_n, porst_n, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic req_valid, req_ready, rsp_valid, fl_go, cpu_subclk;
	logic serial_mode, flash_blank, full_speed, boot_swapped;
	fwg_req_t req, fl_cmd;
	fwg_rsp_t rsp;
	logic [15:0] go_count;
	int err_count = 0;
	int num_checks = 0;
	int cyc = 0;

	fwg_top i_dut (.CLK(clk), .ARST_N(arst_n), .PORST_N(porst_n),
		.PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr),
		.PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .REQ_VALID(req_valid), .REQ(req),
		.REQ_READY(req_ready), .RSP_VALID(rsp_valid), .RSP(rsp),
		.FL_GO(fl_go), .FL_CMD(fl_cmd), .CPU_SUBCLK(cpu_subclk),
		.SERIAL_MODE(serial_mode), .FLASH_BLANK(flash_blank),
		.FULL_SPEED(full_speed), .BOOT_SWAPPED(boot_swapped));
	fwg_flash_model i_flash (.clk(clk), .arst_n(arst_n), .fl_go(fl_go),
		.fl_cmd(fl_cmd), .go_count_r(go_count));

	// ------------------------------------------------------------
	// bus and request helpers
	// ------------------------------------------------------------
	// 200 MHz clock and a hang limit
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_count++;
			complete_run();
		end
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x) begin
			err_count++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask : chk

	// one apb transfer, held until pready is seen high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic e);
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		#1;
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		apb(1'b1, a, d, q, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] x);
		logic [31:0] q;
		logic e;
		apb(1'b0, a, 32'h0000_0000, q, e);
		`CHK(q, x);
	endtask : rd

	// f holds serial, write and data flash flags
	function automatic fwg_req_t rq(input logic [2:0] f,
		input logic [19:0] a);
		rq = {f, a};
	endfunction : rq

	// one request, judged in its answer cycle and at the array
	task automatic ask(input fwg_req_t r, input fwg_code_t c);
		logic [15:0] c0;
		c0 = go_count;
		@(posedge clk);
		req_valid <= 1'b1;
		req <= r;
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		`CHK(rsp_valid, 1'b1);
		`CHK(req_ready, 1'b0);
		`CHK(rsp, {c != FWG_OK, c});
		`CHK(fl_go, c == FWG_OK);
		if (c == FWG_OK) `CHK(fl_cmd, r);
		@(posedge clk);
		#1;
		`CHK(go_count, c0 + (c == FWG_OK));
	endtask : ask

	task automatic pulse_reset();
		@(posedge clk);
		arst_n <= 1'b0;
		repeat (2) @(posedge clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge clk);
		#1;
	endtask : pulse_reset

	task automatic complete_run();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : complete_run

	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task automatic t_shipped();
		logic [31:0] q;
		logic e;
		rd(FWG_OFS_SEC, 32'h0000_0000);
		rd(FWG_OFS_WIN, 32'h03FF_0000);
		`CHK(boot_swapped, 1'b0);
		ask(rq(3'h0, 20'h0_0000), FWG_OK);
		ask(rq(3'h6, 20'h0_0400), FWG_OK);
		apb(1'b0, 8'h18, 32'h0000_0000, q, e);
		`CHK(e, 1'b1);
		`CHK(q, 32'h0000_0000);
		$display("test shipped done");
	endtask : t_shipped

	task automatic t_volt();
		logic [7:0] v [4];
		// software picks zero for high speed main, others for low modes
		v = '{8'h00, 8'h01, 8'hFF, 8'h00};
		foreach (v[i]) begin
			wr(FWG_OFS_VOLT, {24'h00_0000, v[i]});
			`CHK(full_speed, v[i] == 8'h00);
		end
		$display("test volt done");
	endtask : t_volt

	task automatic t_subclk();
		@(posedge clk);
		cpu_subclk <= 1'b1;
		ask(rq(3'h0, 20'h0_2000), FWG_SUBCLK);
		ask(rq(3'h2, 20'h0_2000), FWG_SUBCLK);
		ask(rq(3'h6, 20'h0_2000), FWG_OK);
		@(posedge clk);
		cpu_subclk <= 1'b0;
		$display("test subclk done");
	endtask : t_subclk

	task automatic t_window();
		@(posedge clk);
		serial_mode <= 1'b1;
		wr(FWG_OFS_WIN, 32'h0007_0003);
		rd(FWG_OFS_WIN, 32'h0007_0003);
		@(posedge clk);
		serial_mode <= 1'b0;
		wr(FWG_OFS_WIN, 32'h0006_0004);
		rd(FWG_OFS_WIN, 32'h0006_0004);
		ask(rq(3'h0, 20'h0_0FFF), FWG_WINDOW);
		ask(rq(3'h0, 20'h0_1000), FWG_OK);
		ask(rq(3'h2, 20'h0_1BFF), FWG_OK);
		ask(rq(3'h2, 20'h0_1C00), FWG_WINDOW);
		ask(rq(3'h1, 20'h0_1C00), FWG_OK);
		ask(rq(3'h6, 20'h0_1C00), FWG_OK);
		ask(rq(3'h4, 20'h0_0000), FWG_OK);
		$display("test window done");
	endtask : t_window

	task automatic t_release();
		@(posedge clk);
		serial_mode <= 1'b1;
		flash_blank <= 1'b1;
		wr(FWG_OFS_SEC, 32'h0000_0002);
		wr(FWG_OFS_REL, 32'h0000_0001);
		rd(FWG_OFS_SEC, 32'h0000_0002);
		ask(rq(3'h6, 20'h0_1000), FWG_WRITE);
		ask(rq(3'h2, 20'h0_1000), FWG_OK);
		ask(rq(3'h4, 20'h0_1000), FWG_OK);
		pulse_reset();
		rd(FWG_OFS_SEC, 32'h0000_0002);
		wr(FWG_OFS_REL, 32'h0000_0001);
		rd(FWG_OFS_SEC, 32'h0000_0000);
		@(posedge clk);
		serial_mode <= 1'b0;
		flash_blank <= 1'b0;
		$display("test release done");
	endtask : t_release

	task automatic t_swap();
		wr(FWG_OFS_WIN, 32'h0006_0000);
		ask(rq(3'h2, 20'h0_1000), FWG_OK);
		wr(FWG_OFS_SWAP, 32'h0000_0001);
		rd(FWG_OFS_SWAP, 32'h0000_0001);
		`CHK(boot_swapped, 1'b0);
		pulse_reset();
		`CHK(boot_swapped, 1'b1);
		rd(FWG_OFS_SWAP, 32'h0000_0003);
		ask(rq(3'h0, 20'h0_0000), FWG_OK);
		wr(FWG_OFS_SWAP, 32'h0000_0001);
		pulse_reset();
		`CHK(boot_swapped, 1'b0);
		$display("test swap done");
	endtask : t_swap

	task automatic t_guard();
		wr(FWG_OFS_SEC, 32'h0000_0004);
		ask(rq(3'h0, 20'h0_0FFF), FWG_BC0);
		ask(rq(3'h6, 20'h0_0000), FWG_BC0);
		ask(rq(3'h0, 20'h0_1000), FWG_OK);
		wr(FWG_OFS_SEC, 32'h0000_0003);
		rd(FWG_OFS_SEC, 32'h0000_0007);
		ask(rq(3'h4, 20'h0_1400), FWG_ERASE);
		ask(rq(3'h0, 20'h0_1400), FWG_OK);
		ask(rq(3'h6, 20'h0_1400), FWG_WRITE);
		ask(rq(3'h6, 20'h0_0400), FWG_BC0);
		rd(FWG_OFS_STAT, 32'h0000_0035);
		$display("test guard done");
	endtask : t_guard

	// reset, then the scenarios in order
	initial begin
		clk = 1'b0;
		{arst_n, porst_n, psel, penable, pwrite, req_valid} = 6'h00;
		// requesters run on the main clock, outside serial mode, flash not blank
		{cpu_subclk, serial_mode, flash_blank} = 3'h0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		req = '0;
		repeat (5) @(posedge clk);
		arst_n <= 1'b1;
		porst_n <= 1'b1;
		@(posedge clk);
		#1;
		t_shipped();
		t_volt();
		t_subclk();
		t_window();
		t_release();
		t_swap();
		t_guard();
		complete_run();
	end
endmodule : fwg_tb_top
